// ==== shared/scg_pkg.sv ====
// scg_pkg: register map, field layout and mode codes of the sleep-mode
// clock gating block. assumes an AHB-Lite word bus, 32-bit data.
package scg_pkg;

    // ************************************************************
    // base and offsets
    // ************************************************************
    localparam logic [31:0] SCG_SYSCTL_BASE = 32'h400f_e000;
    localparam logic [11:0] SCG_OFS_RUN_GATE = 12'h100;
    localparam logic [11:0] SCG_OFS_SLEEP_GATE = 12'h110;
    localparam logic [11:0] SCG_OFS_DEEP_GATE = 12'h120;
    localparam logic [11:0] SCG_OFS_RUN_CFG = 12'h060;
    localparam logic [11:0] SCG_OFS_IRQ_STATUS = 12'h200;
    localparam logic [11:0] SCG_OFS_IRQ_MASK = 12'h204;

    // ************************************************************
    // field layout
    // ************************************************************
    localparam int SCG_BIT_CAN_UNIT_ZERO_CLOCK_GATE = 24;
    localparam int SCG_BIT_CONV = 16;
    localparam int SCG_BIT_RATE_HI = 9;
    localparam int SCG_BIT_RATE_LO = 8;
    localparam int SCG_BIT_HIB = 6;
    localparam int SCG_BIT_WDT = 3;
    localparam int SCG_BIT_ACG = 27;
    localparam logic [31:0] SCG_GATE_WMASK = 32'h0101_0348;
    localparam logic [31:0] SCG_GATE_RESET = 32'h0000_0040;
    localparam logic [31:0] SCG_CFG_WMASK = 32'h0800_0000;
    localparam logic [31:0] SCG_CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] SCG_IRQ_WMASK = 32'h0000_0003;

    // irq status bits
    localparam int SCG_IRQ_FAULT = 0;
    localparam int SCG_IRQ_MODE = 1;

    // ************************************************************
    // enumerations
    // ************************************************************
    typedef enum logic [1:0] {
        SCG_RATE_125K = 2'h0,
        SCG_RATE_250K = 2'h1,
        SCG_RATE_500K = 2'h2
    } scg_rate_t;

    typedef enum logic [2:0] {
        SCG_MODE_RUN = 3'h1,
        SCG_MODE_SLEEP = 3'h2,
        SCG_MODE_DEEP = 3'h4
    } scg_mode_t;

    localparam int SCG_NUM_UNITS = 4;
endpackage

// ==== src/scg_fault_gate.sv ====
// scg_fault_gate: per-unit access screen; answers an AHB access to an
// unclocked unit with a two-cycle ERROR. assumes hclk domain only.
`timescale 1ns/100ps
module scg_fault_gate
    import scg_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // unit access request (address phase, from the unit decoder)
    input wire logic [SCG_NUM_UNITS-1:0] unit_sel,
    input wire logic access_valid,
    input wire logic hready,
    // current enables
    input wire logic [SCG_NUM_UNITS-1:0] unit_clk_en,
    // fault answer
    output logic fault_resp,
    output logic fault_ready,
    output logic fault_event
);
    typedef enum logic [2:0] {
        SCG_F_IDLE = 3'b001,
        SCG_F_ERR1 = 3'b010,
        SCG_F_ERR2 = 3'b100
    } scg_fstate_t;

    scg_fstate_t state;
    scg_fstate_t next_state;
    logic hit_gated;

    assign hit_gated = access_valid && hready &&
                       |(unit_sel & ~unit_clk_en);

    always_comb begin
        next_state = state;
        case (state)
            SCG_F_IDLE: begin
                if (hit_gated) begin
                    next_state = SCG_F_ERR1;
                end
            end
            SCG_F_ERR1: next_state = SCG_F_ERR2;
            // hready is high in the last error cycle, so a new address
            // phase is taken there and must not be dropped
            SCG_F_ERR2: begin
                if (hit_gated) begin
                    next_state = SCG_F_ERR1;
                end else begin
                    next_state = SCG_F_IDLE;
                end
            end
            default: next_state = SCG_F_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= SCG_F_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // two-cycle error per AHB-Lite: hready low then high
    assign fault_resp = (state != SCG_F_IDLE);
    assign fault_ready = (state != SCG_F_ERR1);
    assign fault_event = (state == SCG_F_ERR1);

    chk_fault_two_cycle: assert property (@(posedge hclk)
        disable iff (!hresetn)
        hit_gated && state != SCG_F_ERR1 |=> fault_resp && !fault_ready
        ##1 fault_resp && fault_ready)
        else $error("gated access not answered with error");
endmodule

// ==== src/scg_sleep_gating.sv ====
// scg_sleep_gating: sleep-mode clock gating register, mode selection of
// the gating word, unit enables and bus fault on unclocked units.
// assumes one AHB-Lite master, hclk at 40 MHz, async low reset.
//
// Overview of operation
// - a set gating bit clocks its unit; a clear bit stops it.
// - access to an unclocked unit gets an AHB error response.
// - gating bits reset cleared except bit 6; whole register resets to 0x00000040.
// - bit 6 gates hibernation, read/write, resets to one.
// - bit 3 gates watchdog, read/write, resets zero; gated access faults.
// - bits 9:8 select converter rate 500K, 250K or 125K; reset zero.
// - reserved bits are read-only and read as zero.
// - register sits at offset 0x110 from base 0x400fe000.
// - run word in run, sleep word in sleep, deep word in deep sleep.
// - sleep and deep words used only with auto gating select set, else run word.
`timescale 1ns/100ps
module scg_sleep_gating
    import scg_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // unit window decode from the system address decoder
    input wire logic [SCG_NUM_UNITS-1:0] unit_sel,
    // processor power state
    input wire logic sleep_req,
    input wire logic deep_sleep_req,
    // gated unit clock enables
    output logic can_unit_zero_clock_gate_clk_en,
    output logic conv_clk_en,
    output logic hib_clk_en,
    output logic wdt_clk_en,
    output logic [1:0] conv_rate,
    // interrupt
    output logic irq
);
    // ************************************************************
    // address phase capture
    // ************************************************************
    function automatic logic ofs_hit(input logic [31:0] a,
                                     input logic [11:0] ofs);
        ofs_hit = (a[31:12] == SCG_SYSCTL_BASE[31:12]) && (a[11:0] == ofs);
    endfunction

    logic ap_ok;
    logic dp_wr;
    logic dp_rd;
    logic [31:0] dp_addr;
    logic [31:0] run_gate;
    logic [31:0] sleep_gate;
    logic [31:0] deep_gate;
    logic [31:0] run_cfg;
    logic [31:0] irq_status;
    logic [31:0] irq_mask;
    logic [31:0] next_rdata;
    logic [31:0] active_gate;
    logic [31:0] next_irq_status;
    logic [SCG_NUM_UNITS-1:0] unit_en;
    logic fault_resp;
    logic fault_ready;
    logic fault_event;
    logic mode_change;
    logic reg_sel_ok;
    scg_mode_t mode;
    scg_mode_t prev_mode;

    // register window excludes unit windows so faulting cannot hit it
    assign reg_sel_ok = hsel && ~|unit_sel;
    assign ap_ok = reg_sel_ok && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr <= 1'b0;
            dp_rd <= 1'b0;
            dp_addr <= 32'h0000_0000;
        end else if (hready) begin
            dp_wr <= ap_ok && hwrite;
            dp_rd <= ap_ok && !hwrite;
            dp_addr <= haddr;
        end
    end

    // ************************************************************
    // register file
    // ************************************************************
    wire wr_run = dp_wr && ofs_hit(dp_addr, SCG_OFS_RUN_GATE);
    wire wr_sleep = dp_wr && ofs_hit(dp_addr, SCG_OFS_SLEEP_GATE);
    wire wr_deep = dp_wr && ofs_hit(dp_addr, SCG_OFS_DEEP_GATE);
    wire wr_cfg = dp_wr && ofs_hit(dp_addr, SCG_OFS_RUN_CFG);
    wire wr_stat = dp_wr && ofs_hit(dp_addr, SCG_OFS_IRQ_STATUS);
    wire wr_mask = dp_wr && ofs_hit(dp_addr, SCG_OFS_IRQ_MASK);

    // reserved bits never store, so they read as zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sleep_gate <= SCG_GATE_RESET;
        end else if (wr_sleep) begin
            sleep_gate <= hwdata & SCG_GATE_WMASK;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_gate <= SCG_GATE_RESET;
            deep_gate <= SCG_GATE_RESET;
        end else begin
            if (wr_run) begin
                run_gate <= hwdata & SCG_GATE_WMASK;
            end
            if (wr_deep) begin
                deep_gate <= hwdata & SCG_GATE_WMASK;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_cfg <= SCG_CFG_RESET;
            irq_mask <= 32'h0000_0000;
        end else begin
            if (wr_cfg) begin
                run_cfg <= hwdata & SCG_CFG_WMASK;
            end
            if (wr_mask) begin
                irq_mask <= hwdata & SCG_IRQ_WMASK;
            end
        end
    end

    // ************************************************************
    // mode and gating selection
    // ************************************************************
    wire auto_clock_gating_select = run_cfg[SCG_BIT_ACG];

    assign mode = deep_sleep_req ? SCG_MODE_DEEP :
                  sleep_req ? SCG_MODE_SLEEP : SCG_MODE_RUN;

    // without auto gating every low-power state keeps the run word
    assign active_gate = !auto_clock_gating_select ? run_gate :
                         (mode == SCG_MODE_SLEEP) ? sleep_gate :
                         (mode == SCG_MODE_DEEP) ? deep_gate :
                         run_gate;

    assign can_unit_zero_clock_gate_clk_en = active_gate[SCG_BIT_CAN_UNIT_ZERO_CLOCK_GATE];
    assign conv_clk_en = active_gate[SCG_BIT_CONV];
    assign hib_clk_en = active_gate[SCG_BIT_HIB];
    assign wdt_clk_en = active_gate[SCG_BIT_WDT];
    assign conv_rate = active_gate[SCG_BIT_RATE_HI:SCG_BIT_RATE_LO];
    assign unit_en = {can_unit_zero_clock_gate_clk_en, conv_clk_en, hib_clk_en, wdt_clk_en};

    // ************************************************************
    // bus fault on gated units
    // ************************************************************
    scg_fault_gate u_fault (
        .hclk(hclk),
        .hresetn(hresetn),
        .unit_sel(unit_sel),
        .access_valid(htrans[1]),
        .hready(hready),
        .unit_clk_en(unit_en),
        .fault_resp(fault_resp),
        .fault_ready(fault_ready),
        .fault_event(fault_event)
    );

    assign hresp = fault_resp;
    assign hreadyout = fault_ready;

    // ************************************************************
    // read data
    // ************************************************************
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (ofs_hit(dp_addr, SCG_OFS_SLEEP_GATE)) begin
            next_rdata = sleep_gate;
        end else if (ofs_hit(dp_addr, SCG_OFS_RUN_GATE)) begin
            next_rdata = run_gate;
        end else if (ofs_hit(dp_addr, SCG_OFS_DEEP_GATE)) begin
            next_rdata = deep_gate;
        end else if (ofs_hit(dp_addr, SCG_OFS_RUN_CFG)) begin
            next_rdata = run_cfg;
        end else if (ofs_hit(dp_addr, SCG_OFS_IRQ_STATUS)) begin
            next_rdata = irq_status;
        end else if (ofs_hit(dp_addr, SCG_OFS_IRQ_MASK)) begin
            next_rdata = irq_mask;
        end
    end

    // zero-wait: data phase drives the addressed word combinationally
    assign hrdata = dp_rd ? next_rdata : 32'h0000_0000;

    // ************************************************************
    // interrupts
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_mode <= SCG_MODE_RUN;
        end else begin
            prev_mode <= mode;
        end
    end

    assign mode_change = (prev_mode != mode);

    // a set arriving with its own clear wins
    always_comb begin
        next_irq_status = irq_status;
        if (wr_stat) begin
            next_irq_status = irq_status & ~(hwdata & SCG_IRQ_WMASK);
        end
        if (fault_event) begin
            next_irq_status[SCG_IRQ_FAULT] = 1'b1;
        end
        if (mode_change) begin
            next_irq_status[SCG_IRQ_MODE] = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= 32'h0000_0000;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    assign irq = |(irq_status & irq_mask);

    // ************************************************************
    // checks
    // ************************************************************
    chk_sleep_word_used: assert property (@(posedge hclk)
        disable iff (!hresetn)
        auto_clock_gating_select && sleep_req && !deep_sleep_req |->
        hib_clk_en == sleep_gate[SCG_BIT_HIB] &&
        wdt_clk_en == sleep_gate[SCG_BIT_WDT])
        else $error("sleep word not applied in sleep");

    chk_no_acg_run: assert property (@(posedge hclk)
        disable iff (!hresetn)
        !auto_clock_gating_select |-> can_unit_zero_clock_gate_clk_en == run_gate[SCG_BIT_CAN_UNIT_ZERO_CLOCK_GATE] &&
        conv_clk_en == run_gate[SCG_BIT_CONV])
        else $error("run word not in force without auto gating");

    chk_reserved_zero: assert property (@(posedge hclk)
        disable iff (!hresetn)
        (sleep_gate & ~SCG_GATE_WMASK) == 32'h0000_0000)
        else $error("reserved bit stored");

    chk_sleep_write: assert property (@(posedge hclk)
        disable iff (!hresetn)
        wr_sleep |=> sleep_gate == ($past(hwdata) & SCG_GATE_WMASK))
        else $error("sleep word write lost");

    chk_sleep_readback: assert property (@(posedge hclk)
        disable iff (!hresetn)
        dp_rd && ofs_hit(dp_addr, SCG_OFS_SLEEP_GATE) |->
        hrdata == sleep_gate)
        else $error("sleep word readback wrong");

    chk_rate_follows: assert property (@(posedge hclk)
        disable iff (!hresetn)
        auto_clock_gating_select && sleep_req && !deep_sleep_req |->
        conv_rate == sleep_gate[SCG_BIT_RATE_HI:SCG_BIT_RATE_LO])
        else $error("rate field not applied");

    chk_fault_gated: assert property (@(posedge hclk)
        disable iff (!hresetn)
        htrans[1] && hready && unit_sel[0] && !wdt_clk_en &&
        !fault_resp |=> hresp ##1 hresp && hreadyout)
        else $error("watchdog gated access did not fault");

    chk_enabled_ok: assert property (@(posedge hclk)
        disable iff (!hresetn)
        htrans[1] && hready && !fault_resp &&
        |unit_sel && (unit_sel & ~unit_en) == '0 |=> !hresp)
        else $error("clocked unit access faulted");

    chk_reset_value: assert property (@(posedge hclk)
        $rose(hresetn) |-> sleep_gate == SCG_GATE_RESET)
        else $error("reset value wrong");

    chk_hib_reset: assert property (@(posedge hclk)
        $rose(hresetn) |-> hib_clk_en && !wdt_clk_en &&
        !can_unit_zero_clock_gate_clk_en && !conv_clk_en)
        else $error("unit enables wrong after reset");

    chk_fault_status: assert property (@(posedge hclk)
        disable iff (!hresetn)
        fault_event |=> irq_status[SCG_IRQ_FAULT])
        else $error("gated access fault not recorded");
endmodule

// ==== test/scg_unit_model.sv ====
// scg_unit_model: the gated peripheral units beside the gating block.
// assumes unit i decodes at 0x4000_0000 + i*0x1000, all in hclk domain.
`timescale 1ns/100ps
module scg_unit_model
    import scg_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus address phase
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    // enables from the gating block
    input wire logic [SCG_NUM_UNITS-1:0] unit_en,
    // window decode and unit activity
    output logic [SCG_NUM_UNITS-1:0] unit_sel,
    output logic [15:0] ticks [SCG_NUM_UNITS]
);
    // ************************************************************
    // units
    // ************************************************************
    for (genvar i = 0; i < SCG_NUM_UNITS; i++) begin : g_dec
        assign unit_sel[i] = htrans[1] && haddr[31:16] == 16'h4000 &&
                             haddr[15:12] == 4'(i);
    end

    // a unit only advances while its clock runs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < SCG_NUM_UNITS; i++) begin
                ticks[i] <= 16'h0;
            end
        end else begin
            for (int i = 0; i < SCG_NUM_UNITS; i++) begin
                if (unit_en[i]) begin
                    ticks[i] <= ticks[i] + 16'h1;
                end
            end
        end
    end
endmodule

// ==== test/scg_sleep_gating_tb.sv ====
// scg_sleep_gating_tb: self-checking bench for the sleep gating block.
// assumes one AHB-Lite master here and the unit model as decoder.
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin \
    err_total++; $display("wrong value %s exp %h got %h", nm, exp, got); \
    end end
module scg_sleep_gating_tb
    import scg_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hready, sleep_req, deep_sleep_req;
    logic [31:0] haddr, hwdata, hrdata, rd, w;
    logic [1:0] htrans, conv_rate;
    logic hreadyout, hresp, can_unit_zero_clock_gate_clk_en, conv_clk_en, hib_clk_en;
    logic wdt_clk_en, irq, rsp;
    logic [3:0] unit_sel;
    logic [5:0] outs;
    logic [15:0] ticks [SCG_NUM_UNITS];
    logic [15:0] t0;
    logic [31:0] words [3];
    int err_total = 0;
    int comparisons = 0;
    int waits;

    assign hready = hreadyout;
    assign outs = {can_unit_zero_clock_gate_clk_en, conv_clk_en, hib_clk_en, wdt_clk_en,
                   conv_rate};

    scg_sleep_gating DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .unit_sel(unit_sel),
        .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
        .can_unit_zero_clock_gate_clk_en(can_unit_zero_clock_gate_clk_en), .conv_clk_en(conv_clk_en),
        .hib_clk_en(hib_clk_en), .wdt_clk_en(wdt_clk_en),
        .conv_rate(conv_rate), .irq(irq));

    scg_unit_model units (.hclk(hclk), .hresetn(hresetn), .haddr(haddr),
        .htrans(htrans), .unit_en(outs[5:2]), .unit_sel(unit_sel),
        .ticks(ticks));

    // ************************************************************
    // bus tasks and expectations
    // ************************************************************
    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd);
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsel <= 1'b1;
        // no wait limit here: only the bench watchdog ends a hang
        do begin
            @(posedge hclk);
        end while (!hready);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        rsp = 1'b0;
        waits = 0;
        do begin
            @(posedge hclk);
            rsp = rsp | hresp;
            waits += int'(!hready);
        end while (!hready);
        rd = hrdata;
    endtask

    function automatic logic [31:0] ra(input logic [11:0] ofs);
        return SCG_SYSCTL_BASE + {20'h0, ofs};
    endfunction

    task automatic wr(input logic [11:0] ofs, input logic [31:0] d);
        bus(1'b1, ra(ofs), d);
    endtask

    task automatic rdchk(input string nm, input logic [11:0] ofs,
                         input logic [31:0] exp);
        bus(1'b0, ra(ofs), 32'h0);
        `CHK(nm, exp, rd)
    endtask

    function automatic logic [5:0] gate_of(input logic [31:0] g);
        return {g[SCG_BIT_CAN_UNIT_ZERO_CLOCK_GATE], g[SCG_BIT_CONV], g[SCG_BIT_HIB],
                g[SCG_BIT_WDT], g[SCG_BIT_RATE_HI:SCG_BIT_RATE_LO]};
    endfunction

    // legal rates only, the converter maximum is never exceeded
    function automatic logic [31:0] rnd_word();
        logic [31:0] v;
        v = $urandom;
        v[9:8] = 2'($urandom_range(2));
        return v;
    endfunction

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ************************************************************
    // clock, watchdog, tests
    // ************************************************************
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    initial begin
        #(25 * 6000);
        err_total++;
        tally_and_finish();
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        sleep_req = 1'b0;
        deep_sleep_req = 1'b0;
        void'($urandom(32'h807686a7));
        repeat (6) @(posedge hclk);
        `CHK("reset enables", 6'h08, outs)
        hresetn <= 1'b1;
        rdchk("sleep reset", SCG_OFS_SLEEP_GATE, 32'h0000_0040);
        rdchk("run reset", SCG_OFS_RUN_GATE, 32'h0000_0040);
        rdchk("cfg reset", SCG_OFS_RUN_CFG, 32'h0);
        for (int i = 0; i < 10; i++) begin
            w = (i == 0) ? 32'hffff_feff : rnd_word();
            wr(SCG_OFS_SLEEP_GATE, w);
            rdchk("sleep rw", SCG_OFS_SLEEP_GATE, w & 32'h0101_0348);
        end
        wr(12'h300, 32'hffff_ffff);
        rdchk("unmapped", 12'h300, 32'h0);
        for (int i = 0; i < 3; i++) begin
            words[i] = rnd_word();
            words[i][9:8] = 2'(i);
        end
        wr(SCG_OFS_RUN_GATE, words[0]);
        wr(SCG_OFS_SLEEP_GATE, words[1]);
        wr(SCG_OFS_DEEP_GATE, words[2]);
        for (int a = 0; a < 2; a++) begin
            wr(SCG_OFS_RUN_CFG, a ? 32'h0800_0000 : 32'h0);
            for (int m = 0; m < 3; m++) begin
                sleep_req <= (m == 1);
                deep_sleep_req <= (m == 2);
                repeat (3) @(posedge hclk);
                `CHK("mode gate", gate_of(words[a ? m : 0]), outs)
            end
        end
        sleep_req <= 1'b0;
        deep_sleep_req <= 1'b0;
        wr(SCG_OFS_RUN_CFG, 32'h0);
        wr(SCG_OFS_IRQ_STATUS, 32'h3);
        wr(SCG_OFS_IRQ_MASK, 32'h0);
        for (int u = 0; u < 4; u++) begin
            wr(SCG_OFS_RUN_GATE, 32'h0);
            bus(1'b0, 32'h4000_0000 + 32'(u) * 32'h1000, 32'h0);
            `CHK("gated fault", 2'b11, {rsp, waits == 1})
            `CHK("masked irq", 1'b0, irq)
            wr(SCG_OFS_RUN_GATE, 32'h0101_0048);
            bus(1'b1, 32'h4000_0000 + 32'(u) * 32'h1000, $urandom);
            `CHK("clocked ok", 2'b00, {rsp, waits == 1})
        end
        rdchk("fault status", SCG_OFS_IRQ_STATUS, 32'h1);
        // the write lands at the task's last edge; look one edge later
        wr(SCG_OFS_IRQ_MASK, 32'h1);
        @(posedge hclk);
        `CHK("irq on", 1'b1, irq)
        wr(SCG_OFS_IRQ_STATUS, 32'h1);
        @(posedge hclk);
        `CHK("irq clear", 1'b0, irq)
        wr(SCG_OFS_RUN_GATE, 32'h0000_0008);
        @(posedge hclk);
        t0 = ticks[0];
        repeat (5) @(posedge hclk);
        `CHK("wdt runs", 16'h5, 16'(ticks[0] - t0))
        wr(SCG_OFS_RUN_GATE, 32'h0);
        @(posedge hclk);
        t0 = ticks[0];
        repeat (5) @(posedge hclk);
        `CHK("wdt stopped", 16'h0, 16'(ticks[0] - t0))
        tally_and_finish();
    end
endmodule
